// >>> include/engine_pkg.sv
// Constants for the engine feature enable and level readback register bank.
// Overview of operation
// - Limiter off stops new gain reduction, not gain recovery.
// - Limiter gain recovery runs except during attack.
// - Limiter off applies fixed maximum gain.
// - Feature bit 1 enables limiter, resets one.
// - Feature bit 0 gates engine clock, resets one.
// - Coefficient writes discarded while clock gate clear.
// - Run bit acts only at program start.
// - Engine writes level, converted to dB automatically.
// - Level field 8 bits, read-only, 0.375 dB steps.
package engine_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [9:0] FEAT_IDX = 10'h00B;
   localparam logic [9:0] LVL_IDX = 10'h00C;
   localparam logic [9:0] COEF_LO_IDX = 10'h0E0;
   localparam logic [9:0] COEF_HI_IDX = 10'h2BF;
   // Field positions and values after reset.
   localparam int CLK_GATE_BIT = 0;
   localparam int ATTACK_EN_BIT = 1;
   localparam logic [1:0] FEAT_RST = 2'h3;
   localparam logic [7:0] LVL_RST = 8'h00;
   // Level conversion: lowest octave position and the top bit that normalisation targets.
   localparam logic [4:0] DB_FLOOR_MSB = 5'h08;
   localparam logic [4:0] DB_TOP_MSB = 5'h17;
   // Limiter gain at full scale, and its value after reset.
   localparam logic [15:0] LIM_GAIN_MAX = 16'hFFFF;
endpackage

// >>> rtl/engine_enable_ctrl.sv
// Engine feature enable, coefficient write gate, limiter gain and level readback.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module engine_enable_ctrl
   import engine_pkg::*;
#(
   parameter logic [15:0] ATTACK_STEP = 16'h0100,
   parameter logic [15:0] DECAY_STEP = 16'h0010
) (
   input wire logic clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Engine side, same clock.
   input wire logic run_req,
   input wire logic prog_start,
   input wire logic lim_over,
   input wire logic lvl_wr_en,
   input wire logic [23:0] lvl_wr_data,
   output logic core_clk_en,
   output logic core_running,
   output logic limiter_attack_enable,
   output logic [15:0] lim_gain,
   output logic coef_wr_en,
   output logic [9:0] coef_wr_addr,
   output logic [31:0] coef_wr_data,
   output logic [7:0] level_db_value
);

   // Converts a linear magnitude to a dB code, 16 codes per octave.
   function automatic logic [7:0] lin_to_db(input logic [23:0] x);
      logic [4:0] p;
      logic [23:0] s;
      logic [7:0] c;
      p = '0;
      for (int i = 0; i < 24; i++) begin
         if (x[i]) begin
            p = 5'(i);
         end
      end
      // Normalise the leading one to bit 23; the four bits below it give the step inside the octave.
      s = x << (DB_TOP_MSB - p);
      // Anything below the lowest octave clamps to the bottom code rather than wrapping.
      if (p < DB_FLOOR_MSB) begin
         c = '0;
      end else begin
         c = {4'(p - DB_FLOOR_MSB), s[22:19]};
      end
      return c;
   endfunction

   logic [1:0] feat_r, feat_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic coef_en_r, coef_en_nxt;
   logic [9:0] coef_addr_r, coef_addr_nxt;
   logic [31:0] coef_data_r, coef_data_nxt;
   logic [15:0] gain_r, gain_nxt;
   logic [15:0] lim_gain_r, lim_gain_nxt;
   logic running_r, running_nxt;
   logic [7:0] level_r, level_nxt;
   logic [9:0] idx;
   logic setup, access, hit_feat, hit_lvl, hit_coef;

   // Address decode on the word index.
   assign idx = paddr[11:2];
   assign setup = psel && !penable;
   assign access = psel && penable && pready_r;
   assign hit_feat = idx == FEAT_IDX;
   assign hit_lvl = idx == LVL_IDX;
   assign hit_coef = idx >= COEF_LO_IDX && idx <= COEF_HI_IDX;

   // Bus side: answer one cycle after setup, writes land at the access edge.
   always_comb begin
      feat_nxt = feat_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      pready_nxt = setup;
      coef_en_nxt = 1'b0;
      coef_addr_nxt = coef_addr_r;
      coef_data_nxt = coef_data_r;
      // Error and read data are captured at setup so they stand through the whole access cycle.
      if (setup) begin
         pslverr_nxt = !(hit_feat || hit_lvl || hit_coef);
         prdata_nxt = '0;
         if (!pwrite && hit_feat) begin
            prdata_nxt = 32'(feat_r);
         end
         if (!pwrite && hit_lvl) begin
            prdata_nxt = 32'(level_r);
         end
      end
      if (access && pwrite && hit_feat && pstrb[0]) begin
         feat_nxt = pwdata[1:0];
      end
      // With the engine clock stopped the memory cannot take a write, so it is dropped silently.
      if (access && pwrite && hit_coef && feat_r[CLK_GATE_BIT]) begin
         coef_en_nxt = 1'b1;
         coef_addr_nxt = idx;
         coef_data_nxt = pwdata;
      end
   end

   // Bus side registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         feat_r <= FEAT_RST;
         prdata_r <= '0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         coef_en_r <= 1'b0;
         coef_addr_r <= '0;
         coef_data_r <= '0;
      end else begin
         feat_r <= feat_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         coef_en_r <= coef_en_nxt;
         coef_addr_r <= coef_addr_nxt;
         coef_data_r <= coef_data_nxt;
      end
   end

   // Engine side: limiter gain, run state and level conversion.
   always_comb begin
      gain_nxt = gain_r;
      if (lim_over && feat_r[ATTACK_EN_BIT]) begin
         // Attack only while enabled.
         gain_nxt = gain_r > ATTACK_STEP ? gain_r - ATTACK_STEP : '0;
      end else if (gain_r < LIM_GAIN_MAX - DECAY_STEP) begin
         gain_nxt = gain_r + DECAY_STEP;
      end else begin
         gain_nxt = LIM_GAIN_MAX;
      end
      // Fixed full gain reaches the engine while the limiter is off.
      lim_gain_nxt = feat_r[ATTACK_EN_BIT] ? gain_r : LIM_GAIN_MAX;
      // Run request is taken only at a program pass boundary.
      running_nxt = prog_start ? run_req : running_r;
      level_nxt = lvl_wr_en ? lin_to_db(lvl_wr_data) : level_r;
   end

   // Engine side registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gain_r <= LIM_GAIN_MAX;
         lim_gain_r <= LIM_GAIN_MAX;
         running_r <= 1'b0;
         level_r <= LVL_RST;
      end else begin
         gain_r <= gain_nxt;
         lim_gain_r <= lim_gain_nxt;
         running_r <= running_nxt;
         level_r <= level_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign core_clk_en = feat_r[CLK_GATE_BIT];
   assign limiter_attack_enable = feat_r[ATTACK_EN_BIT];
   assign core_running = running_r;
   assign lim_gain = lim_gain_r;
   assign coef_wr_en = coef_en_r;
   assign coef_wr_addr = coef_addr_r;
   assign coef_wr_data = coef_data_r;
   assign level_db_value = level_r;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_answer;
      pready ##1 !pready;
   endsequence

   sequence s_feat_write;
      access && pwrite && hit_feat && pstrb[0];
   endsequence

   sequence s_coef_open;
      access && pwrite && hit_coef && core_clk_en;
   endsequence

   sequence s_attack;
      lim_over && limiter_attack_enable && gain_r > ATTACK_STEP;
   endsequence

   a_ready_timing: assert property (s_setup |=> s_answer)
      else $error("pready not one cycle after setup");

   a_feat_write: assert property (
      s_feat_write
      |=> {limiter_attack_enable, core_clk_en} == $past(pwdata[1:0]))
      else $error("feature write not applied");

   a_feat_read_zero: assert property (
      setup && !pwrite && hit_feat |=> prdata[31:2] == '0)
      else $error("reserved feature bits not zero");

   a_coef_blocked: assert property (
      access && pwrite && hit_coef && !core_clk_en |=> !coef_wr_en)
      else $error("coefficient write passed while gated");

   a_coef_passed: assert property (
      access && pwrite && hit_coef && core_clk_en
      |=> coef_wr_en && coef_wr_addr == $past(idx))
      else $error("coefficient write lost while enabled");

   a_gain_fixed_off: assert property (
      !limiter_attack_enable |=> lim_gain == LIM_GAIN_MAX)
      else $error("limiter off but gain not maximum");

   a_no_attack_off: assert property (
      !limiter_attack_enable |=> gain_r >= $past(gain_r))
      else $error("gain reduced while limiter off");

   a_decay_runs: assert property (
      !lim_over && gain_r != LIM_GAIN_MAX ##1 !lim_over
      |-> gain_r > $past(gain_r))
      else $error("gain recovery stalled");

   a_run_at_start: assert property (
      !prog_start |=> $stable(core_running))
      else $error("run state changed mid program");

   a_level_full: assert property (
      lvl_wr_en && lvl_wr_data == 24'hFF_FFFF |=> level_db_value == 8'hFF)
      else $error("full scale level not 0xFF");

   a_level_floor: assert property (
      lvl_wr_en && lvl_wr_data < 24'h00_0100 |=> level_db_value == 8'h00)
      else $error("floor level not zero");

   // Bus answer and error flag.
   a_ready_idle: assert property (
      !psel |=> !pready)
      else $error("pready raised without a transfer");

   a_slverr_unmapped: assert property (
      setup && !(hit_feat || hit_lvl || hit_coef)
      |=> pslverr && pready)
      else $error("unmapped access not flagged");

   // Feature register holds between writes and reads back its two bits.
   a_feat_hold: assert property (
      !(access && pwrite && hit_feat && pstrb[0])
      |=> $stable({limiter_attack_enable, core_clk_en}))
      else $error("feature bits changed without a write");

   a_feat_readback: assert property (
      setup && !pwrite && hit_feat
      |=> prdata[1:0] == $past({limiter_attack_enable, core_clk_en}))
      else $error("feature readback wrong");

   // Coefficient strobe is a single pulse inside the memory window.
   a_coef_pulse: assert property (
      coef_wr_en |=> !coef_wr_en)
      else $error("coefficient strobe longer than one cycle");

   a_coef_range: assert property (
      coef_wr_en
      |-> coef_wr_addr >= COEF_LO_IDX && coef_wr_addr <= COEF_HI_IDX)
      else $error("coefficient write outside the memory window");

   a_coef_data: assert property (
      s_coef_open |=> coef_wr_data == $past(pwdata))
      else $error("coefficient data not passed");

   // Limiter gain steps.
   a_attack_step: assert property (
      s_attack |=> gain_r == $past(gain_r) - ATTACK_STEP)
      else $error("attack step wrong");

   a_decay_while_off: assert property (
      !limiter_attack_enable && gain_r < LIM_GAIN_MAX - DECAY_STEP
      |=> gain_r == $past(gain_r) + DECAY_STEP)
      else $error("gain recovery stopped while limiter off");

   a_gain_follows: assert property (
      limiter_attack_enable |=> lim_gain == $past(gain_r))
      else $error("limiter gain not passed while enabled");

   // Run state and level readback.
   a_run_taken: assert property (
      prog_start |=> core_running == $past(run_req))
      else $error("run request not taken at program start");

   a_level_hold: assert property (
      !lvl_wr_en |=> $stable(level_db_value))
      else $error("level changed without an engine write");

   a_level_mid: assert property (
      lvl_wr_en && lvl_wr_data == 24'h80_0000 |=> level_db_value == 8'hF0)
      else $error("half scale level not 0xF0");

   a_level_readback: assert property (
      setup && !pwrite && hit_lvl
      |=> prdata[7:0] == $past(level_db_value) && prdata[31:8] == '0)
      else $error("level readback wrong");

endmodule // engine_enable_ctrl

// >>> test/engine_enable_and_level_readback_test.sv
// Self-checking bench for the engine feature enable and level readback block.
`timescale 1ns/1ps
module engine_enable_and_level_readback_test;
   import engine_pkg::*;
   logic clk = 0;
   logic arst_n = 0;
   logic psel = 0, penable = 0, pwrite = 0, run_req = 0, prog_start = 0, lim_over = 0, lvl_wr_en = 0;
   logic [11:0] paddr = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] pwdata = '0, prdata, coef_wr_data, rd_data;
   logic [23:0] lvl_wr_data = '0;
   logic pready, pslverr, core_clk_en, core_running, limiter_attack_enable, coef_wr_en, rd_err;
   logic [15:0] lim_gain;
   logic [9:0] coef_wr_addr;
   logic [7:0] level_db_value;
   int err_count = 0;
   int check_count = 0;

   // Free-running 250 MHz clock.
   always #2 clk = ~clk;

   engine_enable_ctrl engine_enable_ctrl_i (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .run_req(run_req), .prog_start(prog_start), .lim_over(lim_over),
      .lvl_wr_en(lvl_wr_en), .lvl_wr_data(lvl_wr_data), .core_clk_en(core_clk_en),
      .core_running(core_running), .limiter_attack_enable(limiter_attack_enable), .lim_gain(lim_gain),
      .coef_wr_en(coef_wr_en), .coef_wr_addr(coef_wr_addr), .coef_wr_data(coef_wr_data),
      .level_db_value(level_db_value));

   // Compares one value and counts it.
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; read data and error are taken at the edge that sees pready, the watchdog ends a hang.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Reset values, reserved bits and refused accesses.
   task t_regs();
      chk("clk_en", 1, core_clk_en);
      chk("gain", 32'h0000_FFFF, lim_gain);
      apb(0, 12'h02C, 0);
      chk("feat", 32'h0000_0003, rd_data);
      apb(1, 12'h02C, 32'h0000_00FC);
      #1 chk("limiter_attack_enable", 0, limiter_attack_enable);
      chk("clk_off", 0, core_clk_en);
      apb(0, 12'h02C, 0);
      chk("feat_rsv", 0, rd_data);
      pstrb <= 4'hE;
      apb(1, 12'h02C, 32'h0000_0003);
      pstrb <= 4'hF;
      #1 chk("strb_ign", 0, core_clk_en);
      apb(1, 12'h380, 32'h1234_5678);
      #1 chk("coef_blk", 0, coef_wr_en);
      apb(1, 12'h02C, 32'h0000_0003);
      apb(1, 12'h380, 32'h1234_5678);
      #1 chk("coef_en", 1, coef_wr_en);
      chk("coef_lo", 32'h0000_00E0, coef_wr_addr);
      chk("coef_d", 32'h1234_5678, coef_wr_data);
      apb(1, 12'hAFC, 32'h0000_0001);
      #1 chk("coef_hi", 32'h0000_02BF, coef_wr_addr);
      apb(1, 12'h030, 32'h0000_00FF);
      apb(0, 12'h030, 0);
      chk("lvl_ro", 0, rd_data);
      apb(0, 12'h040, 0);
      chk("unmapped", 1, rd_err);
   endtask

   // Engine level writes appear as dB codes, locally and over APB.
   task t_level();
      logic [23:0] din [6];
      logic [7:0] dex [6];
      din = '{24'hFF_FFFF, 24'h80_0000, 24'h00_8000, 24'h00_0180, 24'h00_0100, 24'h00_00FF};
      dex = '{8'hFF, 8'hF0, 8'h70, 8'h08, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         lvl_wr_en <= 1;
         lvl_wr_data <= din[i];
         @(posedge clk);
         lvl_wr_en <= 0;
         #1 chk("lvl", {24'h0, dex[i]}, {24'h0, level_db_value});
         apb(0, 12'h030, 0);
         chk("lvl_rd", {24'h0, dex[i]}, rd_data);
      end
   endtask

   // Attack when enabled, fixed gain when off, recovery while off.
   task t_limiter();
      @(posedge clk);
      lim_over <= 1;
      repeat (4) @(posedge clk);
      lim_over <= 0;
      @(posedge clk);
      #1 chk("attack", 32'h0000_FBFF, lim_gain);
      apb(1, 12'h02C, 32'h0000_0001);
      lim_over <= 1;
      repeat (80) @(posedge clk);
      lim_over <= 0;
      #1 chk("fixed", 32'h0000_FFFF, lim_gain);
      apb(1, 12'h02C, 32'h0000_0003);
      repeat (2) @(posedge clk);
      #1 chk("decay", 32'h0000_FFFF, lim_gain);
   endtask

   // Run request is taken only at program start.
   task t_run();
      @(posedge clk);
      run_req <= 1;
      @(posedge clk);
      prog_start <= 1;
      @(posedge clk);
      prog_start <= 0;
      run_req <= 0;
      #1 chk("run_on", 1, core_running);
      repeat (3) @(posedge clk);
      prog_start <= 1;
      #1 chk("run_hold", 1, core_running);
      @(posedge clk);
      prog_start <= 0;
      #1 chk("run_off", 0, core_running);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task tally_and_finish();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence.
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1;
      t_regs();
      t_level();
      t_limiter();
      @(posedge clk);
      t_run();
      tally_and_finish();
   end

   // Watchdog against a hang.
   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end
endmodule // engine_enable_and_level_readback_test
